// file: src/ddr_extended_mode_register.sv
// Functional notes
// - setting undefined after power-up; flagged invalid until first load.
// - load command: all four strobes low, bank bit 0 high, bank bit 1 low.
// - address and bank lines of the load cycle become the new contents.
// - reprogramming allowed in use, same command and spacing, banks idle.
// - address bit 0: 0 enables the delay-locked loop, 1 disables it.
// - bits 6 and 1 select drive: full, weak, reserved, matched impedance.
`default_nettype none
module ddr_extended_mode_register (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire demr_pkg::demr_pins_t cmdPins,
  input wire logic banksIdle,
  output demr_pkg::demr_status_t status
);

  demr_pkg::demr_state_t s_r;
  demr_pkg::demr_state_t s_nxt;
  demr_pkg::demr_fields_t shadowFields;
  demr_pkg::demr_cmd_e_t cmdKind;
  logic cmdLive;
  logic cmdIsIdle;

  function automatic demr_pkg::demr_cmd_e_t cmdClass(
    input demr_pkg::demr_pins_t p
  );
    demr_pkg::demr_cmd_e_t k;
    k = demr_pkg::CMD_OTHER;
    if (p.csN) begin
      k = demr_pkg::CMD_DESELECT;
    end else if (p.rasN && p.casN && p.weN) begin
      k = demr_pkg::CMD_NOP;
    end else if (!p.rasN && !p.casN && !p.weN) begin
      // mode loads are told apart by the bank lines alone
      if (p.ba == demr_pkg::EXT_BANK) begin
        k = demr_pkg::CMD_EXT_LOAD;
      end else if (p.ba == demr_pkg::BASE_BANK) begin
        k = demr_pkg::CMD_BASE_LOAD;
      end else begin
        k = demr_pkg::CMD_OTHER;
      end
    end
    return k;
  endfunction

  // fields are decoded from the captured word, not from the live pins,
  // so a bus that moves during the interval cannot disturb the result
  demr_field_map u_field_map (
    .word(s_r.shadow),
    .fields(shadowFields)
  );

  always_comb begin
    cmdKind = cmdClass(cmdPins);
    // a command counts only with clock enable high now and a cycle before
    cmdLive = cmdPins.cke && s_r.ckePrev;
    cmdIsIdle = (cmdKind == demr_pkg::CMD_DESELECT) ||
                (cmdKind == demr_pkg::CMD_NOP);
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.ckePrev = cmdPins.cke;

    // event outputs are single-cycle strobes
    s_nxt.status.loadAccepted = 1'b0;
    s_nxt.status.settingApplied = 1'b0;
    s_nxt.status.earlyCmdErr = 1'b0;
    s_nxt.status.notIdleErr = 1'b0;
    s_nxt.status.reservedBitErr = 1'b0;
    s_nxt.status.reservedCodeErr = 1'b0;

    case (s_r.phase)
      demr_pkg::PH_UNSET,
      demr_pkg::PH_IDLE: begin
        if (cmdLive && cmdKind == demr_pkg::CMD_EXT_LOAD) begin
          if (!banksIdle) begin
            // an active bank makes the load unsafe; it is dropped whole
            s_nxt.status.notIdleErr = 1'b1;
          end else begin
            s_nxt.shadow = cmdPins.addr;
            s_nxt.shadowBank = cmdPins.ba;
            s_nxt.status.loadedWord = cmdPins.addr;
            s_nxt.status.loadedBank = cmdPins.ba;
            s_nxt.count = demr_pkg::LOAD_CNT_INIT;
            s_nxt.phase = demr_pkg::PH_WRITING;
            s_nxt.status.loadBusy = 1'b1;
            s_nxt.status.loadAccepted = 1'b1;
          end
        end
      end

      demr_pkg::PH_WRITING: begin
        // anything but deselect or no-op inside the interval is refused
        if (cmdLive && !cmdIsIdle) begin
          s_nxt.status.earlyCmdErr = 1'b1;
        end
        if (s_r.count <= demr_pkg::LOAD_CNT_LAST) begin
          s_nxt.phase = demr_pkg::PH_IDLE;
          s_nxt.count = '0;
          s_nxt.status.loadBusy = 1'b0;
          s_nxt.status.settingApplied = 1'b1;
          s_nxt.status.settingValid = 1'b1;
          s_nxt.status.dllEnable = !shadowFields.dllOff;
          s_nxt.status.reservedBitErr = shadowFields.reservedHit;
          if (shadowFields.codeReserved) begin
            // keep the previous drive rather than an undefined one
            s_nxt.status.reservedCodeErr = 1'b1;
          end else begin
            s_nxt.status.driveCode = shadowFields.driveCode;
            s_nxt.status.weakDrive =
              (shadowFields.driveCode == demr_pkg::DRIVE_WEAK);
            s_nxt.status.matchedDrive =
              (shadowFields.driveCode == demr_pkg::DRIVE_MATCHED);
          end
        end else begin
          s_nxt.count = s_r.count - 2'h1;
        end
      end

      default: begin
        s_nxt = demr_pkg::DEMR_STATE_RST;
      end
    endcase
  end

  // no default setting is assumed: after reset the outputs read zero and
  // settingValid stays low until the first completed load
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= demr_pkg::DEMR_STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign status = s_r.status;

endmodule
`default_nettype wire

// file: src/demr_field_map.sv
`default_nettype none
module demr_field_map (
  input wire logic [demr_pkg::ADDR_W-1:0] word,
  output demr_pkg::demr_fields_t fields
);

  logic [demr_pkg::ADDR_W-1:0] hitBits;

  genvar i;
  generate
    for (i = 0; i < demr_pkg::ADDR_W; i++) begin : g_rsv
      assign hitBits[i] = word[i] & demr_pkg::RESERVED_MASK[i];
    end
  endgenerate

  always_comb begin
    fields.dllOff = word[demr_pkg::DLL_BIT];
    fields.driveCode = {word[demr_pkg::DS_HIGH_BIT],
                        word[demr_pkg::DS_LOW_BIT]};
    fields.reservedHit = |hitBits;
    fields.codeReserved = (fields.driveCode == demr_pkg::DRIVE_RSVD);
  end

endmodule
`default_nettype wire

// file: src/demr_pkg.sv
`default_nettype none
package demr_pkg;

  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;

  // load interval, in clock cycles, from the load command to the next one
  localparam int LOAD_CYCLES = 2;
  localparam int CNT_W = 2;
  localparam logic [CNT_W-1:0] LOAD_CNT_INIT = CNT_W'(LOAD_CYCLES - 1);
  localparam logic [CNT_W-1:0] LOAD_CNT_LAST = 2'h1;

  // bank address that selects the extended register
  localparam logic [BANK_W-1:0] EXT_BANK = 2'h1;
  localparam logic [BANK_W-1:0] BASE_BANK = 2'h0;

  // field positions inside the 13-bit setting word
  localparam int DLL_BIT = 0;
  localparam int DS_LOW_BIT = 1;
  localparam int DS_HIGH_BIT = 6;
  localparam logic [ADDR_W-1:0] RESERVED_MASK = 13'h1fbc;

  // driver strength codes, {high bit, low bit}
  localparam logic [1:0] DRIVE_FULL = 2'h0;
  localparam logic [1:0] DRIVE_WEAK = 2'h1;
  localparam logic [1:0] DRIVE_RSVD = 2'h2;
  localparam logic [1:0] DRIVE_MATCHED = 2'h3;

  typedef struct packed {
    logic cke;
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } demr_pins_t;

  typedef enum logic [2:0] {
    CMD_DESELECT,
    CMD_NOP,
    CMD_EXT_LOAD,
    CMD_BASE_LOAD,
    CMD_OTHER
  } demr_cmd_e_t;

  typedef enum logic [1:0] {
    PH_UNSET,
    PH_IDLE,
    PH_WRITING
  } demr_phase_e_t;

  typedef struct packed {
    logic dllOff;
    logic [1:0] driveCode;
    logic reservedHit;
    logic codeReserved;
  } demr_fields_t;

  typedef struct packed {
    logic settingValid;
    logic dllEnable;
    logic [1:0] driveCode;
    logic weakDrive;
    logic matchedDrive;
    logic loadBusy;
    logic loadAccepted;
    logic settingApplied;
    logic earlyCmdErr;
    logic notIdleErr;
    logic reservedBitErr;
    logic reservedCodeErr;
    logic [BANK_W-1:0] loadedBank;
    logic [ADDR_W-1:0] loadedWord;
  } demr_status_t;

  typedef struct packed {
    demr_phase_e_t phase;
    logic [CNT_W-1:0] count;
    logic ckePrev;
    logic [BANK_W-1:0] shadowBank;
    logic [ADDR_W-1:0] shadow;
    demr_status_t status;
  } demr_state_t;

  localparam demr_state_t DEMR_STATE_RST = '0;

endpackage
`default_nettype wire

// file: verification/ddr_extended_mode_register_tb.sv
`default_nettype none
module ddr_extended_mode_register_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ena = 1'b0;
  logic req = 1'b0;
  logic banksIdle = 1'b1;
  logic [1:0] bank = 2'h0;
  logic [12:0] word = 13'h0;
  logic [15:0] lfsr = 16'h000e;
  logic expValid = 1'b0;
  logic expDll = 1'b0;
  logic [1:0] expDrv = 2'h0;
  logic [12:0] expWord = 13'h0;
  logic [1:0] expBank = 2'h0;
  int n_mismatch = 0;
  int compares = 0;
  demr_pkg::demr_pins_t cmdPins;
  demr_pkg::demr_status_t status;
  demr_ctrl_model ctl_u (.sys_clk, .ena, .req, .bank, .word, .pins(cmdPins));
  ddr_extended_mode_register dut_u (.sys_clk, .sys_rst, .cmdPins, .banksIdle,
    .status);
  initial forever #10 sys_clk = ~sys_clk;
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] res();
    return {3'h0, status.loadBusy, status.weakDrive, status.matchedDrive,
      status.loadedBank, status.settingApplied, status.earlyCmdErr,
      status.reservedCodeErr, status.reservedBitErr, status.settingValid,
      status.dllEnable, status.driveCode};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic load(input logic [12:0] w, input logic [1:0] b,
    input logic idle, input logic dbl);
    logic acc;
    logic rfs;
    logic [1:0] c;
    @(posedge sys_clk);
    acc = idle && b == 2'h1 && ena;
    rfs = !idle && b == 2'h1 && ena;
    c = {w[6], w[1]};
    req <= 1'b1;
    word <= w;
    bank <= b;
    banksIdle <= idle;
    @(posedge sys_clk);
    req <= dbl;
    @(posedge sys_clk);
    req <= 1'b0;
    #1;
    if (acc) expWord = w;
    chk({status.loadBusy, status.loadAccepted, status.notIdleErr,
      status.loadedWord}, {acc, acc, rfs, expWord});
    @(posedge sys_clk);
    #1;
    if (acc) begin
      expValid = 1'b1;
      expBank = b;
      expDll = !w[0];
      if (c != 2'h2) expDrv = c;
    end
    chk(res(), {3'h0, 1'b0, expDrv == demr_pkg::DRIVE_WEAK,
      expDrv == demr_pkg::DRIVE_MATCHED, expBank, acc, dbl && acc,
      acc && c == 2'h2, acc && (w & demr_pkg::RESERVED_MASK) != 0,
      expValid, expDll, expDrv});
    $display("load %h bank %h done", w, b);
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    ena <= 1'b1;
    #1;
    chk(res(), 16'h0);
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      load(13'({i[2], 4'h0, i[1:0]}), 2'h1, 1'b1, 1'b0);
    end
    load(13'h0001, 2'h1, 1'b0, 1'b0);
    load(13'h0001, 2'h0, 1'b1, 1'b0);
    load(13'h0042, 2'h1, 1'b1, 1'b1);
    // clock enable low at the load edge: the command must be ignored
    ena <= 1'b0;
    load(13'h0002, 2'h1, 1'b1, 1'b0);
    ena <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      lfsr = nx(lfsr);
      load(lfsr[12:0], 2'h1, 1'b1, 1'b0);
    end
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    {expValid, expDll, expDrv, expWord, expBank} = '0;
    chk(res(), 16'h0);
    load(13'h0002, 2'h1, 1'b1, 1'b0);
    stop_test();
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    n_mismatch++;
    stop_test();
  end
endmodule
`default_nettype wire

// file: verification/demr_assertions.sv
`default_nettype none
module demr_assertions (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire demr_pkg::demr_pins_t cmdPins,
  input wire logic banksIdle,
  input wire demr_pkg::demr_status_t status
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ckeQ_r;
  logic ld;
  logic [1:0] wc;
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst) ckeQ_r <= 1'b0;
    else ckeQ_r <= cmdPins.cke;
  // clock enable must be high over two edges before a load counts
  assign ld = cmdPins.cke && ckeQ_r && !status.loadBusy &&
    cmdPins[18:15] == 4'h0 && cmdPins.ba == demr_pkg::EXT_BANK;
  assign wc = {status.loadedWord[6], status.loadedWord[1]};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_take; ld && banksIdle |=> status.loadAccepted; endproperty
  a_take: assert property (p_take) else $error("load not taken");
  property p_cap;
    ld && banksIdle |=> status.loadedWord == $past(cmdPins.addr);
  endproperty
  a_cap: assert property (p_cap) else $error("word not captured");
  property p_idle; ld && !banksIdle |=> status.notIdleErr; endproperty
  a_idle: assert property (p_idle) else $error("busy load kept");
  property p_unset;
    !status.settingValid |-> !status.dllEnable && status.driveCode == 2'h0;
  endproperty
  a_unset: assert property (p_unset) else $error("default setting");
  property p_dll;
    status.settingApplied |-> status.dllEnable != status.loadedWord[0];
  endproperty
  a_dll: assert property (p_dll) else $error("dll bit wrong");
  property p_drv;
    status.settingApplied && wc != 2'h2 |-> status.driveCode == wc;
  endproperty
  a_drv: assert property (p_drv) else $error("drive code wrong");
  property p_apply; status.loadAccepted |=> status.settingApplied; endproperty
  a_apply: assert property (p_apply) else $error("not applied");
  property p_hold;
    !status.settingApplied |-> $stable(status.dllEnable) &&
      $stable(status.driveCode);
  endproperty
  a_hold: assert property (p_hold) else $error("setting drifted");
endmodule
bind ddr_extended_mode_register demr_assertions chk_u (.sys_clk, .sys_rst,
  .cmdPins, .banksIdle, .status);
`default_nettype wire

// file: verification/demr_ctrl_model.sv
`default_nettype none
module demr_ctrl_model (
  input wire logic sys_clk,
  input wire logic ena,
  input wire logic req,
  input wire logic [1:0] bank,
  input wire logic [12:0] word,
  output var demr_pkg::demr_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pins = 20'h7ffff;
  // idle lines toggle so stale values never look valid
  always @(posedge sys_clk) begin
    pins.cke <= ena;
    pins[18:0] <= req ? {4'h0, bank, word} : {4'hf, ~pins[14:0]};
  end
endmodule
`default_nettype wire
